/* File: src/serial_unit_defines.svh */
`ifndef SERIAL_UNIT_DEFINES_SVH
`define SERIAL_UNIT_DEFINES_SVH
// Notes on behaviour
// - raise rx full, tx empty, tx done and rx fault requests on flag set.
// - tx empty flag comes out of reset at one.
// - tx done flag comes out of reset at one.
// - software can read the receive line level directly.
// - an all-zero break sets framing, maybe parity; reception keeps going.
// - with transmit disabled the pin follows port direction and level.
// - clearing transmit enable resets the transmitter at once.
// - in synchronous mode no transmit start while a receive error stands.
// - clearing receive enable leaves the error flags as they are.
// - receiver runs from a basic clock at sixteen times the bit rate.
// - start bit falling edge found on the basic clock syncs bit timing.
// - each bit is latched on the eighth basic pulse of its period.
// - frames of nine to twelve bit periods are handled.
// - one receive enable gates full and fault; overrun keeps old data.

// ****************
// register offsets
// ****************
`define ADR_CTRL   4'h0
`define ADR_STATUS 4'h1
`define ADR_TXHOLD 4'h2
`define ADR_RXDATA 4'h3
`define ADR_PORT   4'h4
`define ADR_LINE   4'h5
`define ADR_EVT    4'h6
`define ADR_MASK   4'h7
`define ADR_FORMAT 4'h8

// ****************
// field positions
// ****************
`define CTRL_TXE_IE 0
`define CTRL_RX_IE  1
`define CTRL_TXD_IE 2
`define CTRL_TX_EN  3
`define CTRL_RX_EN  4
`define CTRL_SYNC   5
`define CTRL_PAR_EN 6
`define CTRL_PAR_OD 7
`define FMT_TWO_STP 0
`define FMT_DATA7   1
`define ST_TX_EMPTY 0
`define ST_TX_DONE  1
`define ST_RX_FULL  2
`define ST_OVERRUN  3
`define ST_FRAMING  4
`define ST_PARITY   5
`define PORT_DIR    0
`define PORT_LVL    1
`define EVT_RX_FULL 0
`define EVT_TX_EMPT 1
`define EVT_TX_DONE 2
`define EVT_RX_FLT  3

// ****************
// timing
// ****************
`define OVERSAMPLE    16
`define SUB_LAST      4'hf
`define SAMPLE_SUB    4'h7
`define BASIC_DIV_DEF 8'h0d
`define FRAME_MIN     4'h9
`define FRAME_MAX     4'hc
`endif

/* File: src/serial_unit_pkg.sv */
package serial_unit_pkg;

    typedef enum logic {TX_IDLE, TX_BUSY} tx_state_t;
    typedef enum logic {RX_IDLE, RX_BUSY} rx_state_t;

    typedef struct packed {
        logic data7;
        logic two_stop;
        logic par_odd;
        logic par_en;
        logic sync;
        logic rx_en;
        logic tx_en;
        logic txd_ie;
        logic rx_ie;
        logic txe_ie;
    } ctrl_t;

    typedef struct packed {
        logic parity;
        logic framing;
        logic overrun;
        logic rx_full;
        logic tx_done;
        logic tx_empty;
    } flags_t;

    typedef struct packed {
        ctrl_t       ctrl;
        flags_t      flags;
        logic [7:0]  tx_holding_register;
        logic [7:0]  rdr;
        logic        port_dir;
        logic        port_lvl;
        logic [7:0]  div;
        tx_state_t   tx_st;
        logic [11:0] tx_sh;
        logic [3:0]  tx_bits;
        logic [3:0]  tx_sub;
        rx_state_t   rx_st;
        logic [11:0] rx_sh;
        logic [3:0]  rx_bits;
        logic [3:0]  rx_sub;
        logic        rx_prev;
        logic        line_lvl;
        logic [3:0]  evt;
        logic [3:0]  mask;
        logic        irq;
        logic [3:0]  req;
        logic [7:0]  rdata;
        logic        txd;
        logic        txd_oe_n;
    } state_t;

endpackage

/* File: src/serial_unit.sv */
`timescale 1ns/100ps
`include "serial_unit_defines.svh"

module serial_unit #(
    parameter logic [7:0] BASIC_DIV = `BASIC_DIV_DEF
) (
    input  wire logic       I_REF_CLK,
    input  wire logic       I_SRST,
    input  wire logic [3:0] I_ADDR,
    input  wire logic [7:0] I_WDATA,
    input  wire logic       I_WR,
    input  wire logic       I_RD,
    output logic      [7:0] O_RDATA,
    input  wire logic       I_RXD,
    output logic            O_TXD,
    output logic            O_TXD_OE_N,
    output logic            O_IRQ,
    output logic            O_RX_FULL_REQ,
    output logic            O_TX_EMPTY_REQ,
    output logic            O_TX_DONE_REQ,
    output logic            O_RX_FAULT_REQ
);

    serial_unit_pkg::state_t s;
    serial_unit_pkg::state_t n;
    logic                    tick;
    logic                    rx_done;
    logic                    rx_stop;
    logic                    err;
    logic [11:0]             fr;
    logic [7:0]              rx_data;
    logic [3:0]              set_evt;

    // ****************
    // frame helpers
    // ****************
    function automatic logic [3:0] data_len(input serial_unit_pkg::ctrl_t c);
        data_len = c.data7 ? 4'h7 : 4'h8;
    endfunction

    function automatic logic [3:0] frame_len(input serial_unit_pkg::ctrl_t c);
        frame_len = 4'h1 + data_len(c) + {3'h0, c.par_en} + (c.two_stop ? 4'h2 : 4'h1);
    endfunction

    function automatic logic par_of(input logic [7:0] d, input serial_unit_pkg::ctrl_t c);
        par_of = (^(c.data7 ? {1'b0, d[6:0]} : d)) ^ c.par_odd;
    endfunction

    function automatic logic [11:0] build(input logic [7:0] d,
                                          input serial_unit_pkg::ctrl_t c);
        logic [11:0] f;
        logic [3:0]  dl;
        f  = 12'hfff;
        dl = data_len(c);
        f[0] = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (4'(i) < dl) begin
                f[i + 1] = d[i];
            end
        end
        if (c.par_en) begin
            f[4'h1 + dl] = par_of(d, c);
        end
        build = f;
    endfunction

    assign O_RDATA        = s.rdata;
    assign O_TXD          = s.txd;
    assign O_TXD_OE_N     = s.txd_oe_n;
    assign O_IRQ          = s.irq;
    assign O_RX_FULL_REQ  = s.req[`EVT_RX_FULL];
    assign O_TX_EMPTY_REQ = s.req[`EVT_TX_EMPT];
    assign O_TX_DONE_REQ  = s.req[`EVT_TX_DONE];
    assign O_RX_FAULT_REQ = s.req[`EVT_RX_FLT];

    always_comb begin
        n       = s;
        rx_done = 1'b0;
        fr      = s.rx_sh;
        rx_data = 8'h00;
        err     = s.flags.overrun | s.flags.framing | s.flags.parity;
        // basic clock divider, one tick per sixteenth of a bit
        tick    = (s.div == BASIC_DIV - 8'h01);
        n.div   = tick ? 8'h00 : s.div + 8'h01;

        // ****************
        // register writes
        // ****************
        if (I_WR) begin
            case (I_ADDR)
                `ADR_CTRL: begin
                    n.ctrl.txe_ie  = I_WDATA[`CTRL_TXE_IE];
                    n.ctrl.rx_ie   = I_WDATA[`CTRL_RX_IE];
                    n.ctrl.txd_ie  = I_WDATA[`CTRL_TXD_IE];
                    n.ctrl.tx_en   = I_WDATA[`CTRL_TX_EN];
                    n.ctrl.rx_en   = I_WDATA[`CTRL_RX_EN];
                    n.ctrl.sync    = I_WDATA[`CTRL_SYNC];
                    n.ctrl.par_en  = I_WDATA[`CTRL_PAR_EN];
                    n.ctrl.par_odd = I_WDATA[`CTRL_PAR_OD];
                end
                `ADR_FORMAT: begin
                    n.ctrl.two_stop = I_WDATA[`FMT_TWO_STP];
                    n.ctrl.data7    = I_WDATA[`FMT_DATA7];
                end
                // error flags clear only here, never by receive enable
                `ADR_STATUS: begin
                    n.flags.tx_done = s.flags.tx_done & ~I_WDATA[`ST_TX_DONE];
                    n.flags.rx_full = s.flags.rx_full & ~I_WDATA[`ST_RX_FULL];
                    n.flags.overrun = s.flags.overrun & ~I_WDATA[`ST_OVERRUN];
                    n.flags.framing = s.flags.framing & ~I_WDATA[`ST_FRAMING];
                    n.flags.parity  = s.flags.parity & ~I_WDATA[`ST_PARITY];
                end
                `ADR_TXHOLD: begin
                    n.tx_holding_register            = I_WDATA;
                    n.flags.tx_empty = 1'b0;
                    n.flags.tx_done  = 1'b0;
                end
                `ADR_PORT: begin
                    n.port_dir = I_WDATA[`PORT_DIR];
                    n.port_lvl = I_WDATA[`PORT_LVL];
                end
                `ADR_EVT:  n.evt  = s.evt & ~I_WDATA[3:0];
                `ADR_MASK: n.mask = I_WDATA[3:0];
                default: ;
            endcase
        end
        if (I_RD && I_ADDR == `ADR_RXDATA) begin
            n.flags.rx_full = 1'b0;
        end

        // ****************
        // transmitter
        // ****************
        // losing transmit enable drops any frame in flight
        if (!s.ctrl.tx_en) begin
            n.tx_st   = serial_unit_pkg::TX_IDLE;
            n.tx_bits = 4'h0;
            n.tx_sub  = 4'h0;
        end else begin
            case (s.tx_st)
                serial_unit_pkg::TX_IDLE: begin
                    // a standing receive error blocks a synchronous start
                    if (!s.flags.tx_empty && !(s.ctrl.sync && err)) begin
                        n.tx_sh          = build(s.tx_holding_register, s.ctrl);
                        n.tx_st          = serial_unit_pkg::TX_BUSY;
                        n.tx_bits        = 4'h0;
                        n.tx_sub         = 4'h0;
                        n.flags.tx_empty = 1'b1;
                    end
                end
                serial_unit_pkg::TX_BUSY: begin
                    if (tick) begin
                        n.tx_sub = s.tx_sub + 4'h1;
                        if (s.tx_sub == `SUB_LAST) begin
                            if (s.tx_bits == frame_len(s.ctrl) - 4'h1) begin
                                n.tx_st = serial_unit_pkg::TX_IDLE;
                                // done only when nothing waits to follow
                                if (n.flags.tx_empty) begin
                                    n.flags.tx_done = 1'b1;
                                end
                            end else begin
                                n.tx_bits = s.tx_bits + 4'h1;
                            end
                        end
                    end
                end
                default: n.tx_st = serial_unit_pkg::TX_IDLE;
            endcase
        end

        // ****************
        // receiver
        // ****************
        // raw line level kept for software to read
        n.line_lvl = I_RXD;
        if (tick) begin
            n.rx_prev = I_RXD;
        end
        if (!s.ctrl.rx_en) begin
            n.rx_st = serial_unit_pkg::RX_IDLE;
        end else begin
            case (s.rx_st)
                serial_unit_pkg::RX_IDLE: begin
                    // start edge seen on the basic clock restarts timing
                    if (tick && s.rx_prev && !I_RXD) begin
                        n.rx_st   = serial_unit_pkg::RX_BUSY;
                        n.rx_sub  = 4'h0;
                        n.rx_bits = 4'h0;
                    end
                end
                serial_unit_pkg::RX_BUSY: begin
                    if (tick) begin
                        n.rx_sub = s.rx_sub + 4'h1;
                        // latch on the eighth pulse, mid bit
                        if (s.rx_sub == `SAMPLE_SUB) begin
                            n.rx_sh[s.rx_bits] = I_RXD;
                            if (s.rx_bits == 4'h0 && I_RXD) begin
                                n.rx_st = serial_unit_pkg::RX_IDLE;
                            // length follows data, parity and stop settings
                            end else if (s.rx_bits == frame_len(s.ctrl) - 4'h1) begin
                                rx_done = 1'b1;
                                n.rx_st = serial_unit_pkg::RX_IDLE;
                            end else begin
                                n.rx_bits = s.rx_bits + 4'h1;
                            end
                        end
                    end
                end
                default: n.rx_st = serial_unit_pkg::RX_IDLE;
            endcase
        end
        fr = n.rx_sh;
        for (int i = 0; i < 8; i++) begin
            if (4'(i) < data_len(s.ctrl)) begin
                rx_data[i] = fr[i + 1];
            end
        end
        rx_stop = fr[4'h1 + data_len(s.ctrl) + {3'h0, s.ctrl.par_en}];
        if (rx_done) begin
            // overrun leaves the held byte and its full flag alone
            if (n.flags.rx_full) begin
                n.flags.overrun = 1'b1;
            end else begin
                n.rdr           = rx_data;
                n.flags.rx_full = 1'b1;
            end
            // a break fails the stop bit, so framing sets again
            if (!rx_stop) begin
                n.flags.framing = 1'b1;
            end
            if (s.ctrl.par_en && fr[4'h1 + data_len(s.ctrl)] != par_of(rx_data, s.ctrl)) begin
                n.flags.parity = 1'b1;
            end
        end

        // ****************
        // pin, events, requests
        // ****************
        // port registers own the pin while transmit is off
        n.txd      = n.ctrl.tx_en ? (n.tx_st == serial_unit_pkg::TX_BUSY ?
                                     n.tx_sh[n.tx_bits] : 1'b1) : n.port_lvl;
        n.txd_oe_n = n.ctrl.tx_en ? 1'b0 : ~n.port_dir;
        // rising flags are events; sets override a same-cycle clear
        set_evt[`EVT_RX_FULL] = n.flags.rx_full & ~s.flags.rx_full;
        set_evt[`EVT_TX_EMPT] = n.flags.tx_empty & ~s.flags.tx_empty;
        set_evt[`EVT_TX_DONE] = n.flags.tx_done & ~s.flags.tx_done;
        set_evt[`EVT_RX_FLT]  = (n.flags.overrun & ~s.flags.overrun)
                              | (n.flags.framing & ~s.flags.framing)
                              | (n.flags.parity & ~s.flags.parity);
        n.evt = n.evt | set_evt;
        n.irq = |(n.evt & n.mask);
        // request is flag and enable, as a level
        // transmit requests use their own enables
        n.req[`EVT_RX_FULL] = n.flags.rx_full & n.ctrl.rx_ie;
        n.req[`EVT_TX_EMPT] = n.flags.tx_empty & n.ctrl.txe_ie;
        n.req[`EVT_TX_DONE] = n.flags.tx_done & n.ctrl.txd_ie;
        n.req[`EVT_RX_FLT]  = (n.flags.overrun | n.flags.framing | n.flags.parity)
                            & n.ctrl.rx_ie;

        n.rdata = 8'h00;
        if (I_RD) begin
            case (I_ADDR)
                `ADR_CTRL:   n.rdata = {s.ctrl.par_odd, s.ctrl.par_en, s.ctrl.sync,
                                        s.ctrl.rx_en, s.ctrl.tx_en, s.ctrl.txd_ie,
                                        s.ctrl.rx_ie, s.ctrl.txe_ie};
                `ADR_FORMAT: n.rdata = {6'h00, s.ctrl.data7, s.ctrl.two_stop};
                `ADR_STATUS: n.rdata = {2'h0, s.flags};
                `ADR_TXHOLD: n.rdata = s.tx_holding_register;
                `ADR_RXDATA: n.rdata = s.rdr;
                `ADR_PORT:   n.rdata = {6'h00, s.port_lvl, s.port_dir};
                `ADR_LINE:   n.rdata = {7'h00, s.line_lvl};
                `ADR_EVT:    n.rdata = {4'h0, s.evt};
                `ADR_MASK:   n.rdata = {4'h0, s.mask};
                default:     n.rdata = 8'h00;
            endcase
        end

        if (I_SRST) begin
            n                = '0;
            n.flags.tx_empty = 1'b1;
            n.flags.tx_done  = 1'b1;
            n.rx_prev        = 1'b1;
            n.line_lvl       = 1'b1;
            n.txd_oe_n       = 1'b1;
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        s <= n;
    end

    // ****************
    // checks
    // ****************
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_SRST);

    a_reset_tx_flags: assert property ($past(I_SRST) |-> s.flags.tx_empty && s.flags.tx_done)
        else $error("tx flags not set after reset");
    a_evt_on_rise: assert property ($rose(s.flags.rx_full) |-> s.evt[`EVT_RX_FULL])
        else $error("rx full event missed");
    a_port_owns_pin: assert property (!s.ctrl.tx_en |->
        O_TXD == s.port_lvl && O_TXD_OE_N == !s.port_dir)
        else $error("pin not under port control");
    a_tx_abort: assert property (!s.ctrl.tx_en |=> s.tx_st == serial_unit_pkg::TX_IDLE &&
        s.tx_bits == 4'h0)
        else $error("transmitter not reset");
    a_sync_err_hold: assert property (s.ctrl.tx_en && s.ctrl.sync && err &&
        s.tx_st == serial_unit_pkg::TX_IDLE |=> s.tx_st == serial_unit_pkg::TX_IDLE)
        else $error("start despite receive error");
    a_rx_off_keep: assert property (!s.ctrl.rx_en && !(I_WR && I_ADDR == `ADR_STATUS)
        |=> $stable({s.flags.overrun, s.flags.framing, s.flags.parity}))
        else $error("error flags moved");
    a_bit_period: assert property (s.ctrl.tx_en && s.tx_st == serial_unit_pkg::TX_BUSY &&
        !(tick && s.tx_sub == `SUB_LAST) |=> s.tx_bits == $past(s.tx_bits))
        else $error("bit shorter than sixteen ticks");
    a_start_sync: assert property (s.ctrl.rx_en && s.rx_st == serial_unit_pkg::RX_IDLE &&
        tick && s.rx_prev && !I_RXD |=> s.rx_st == serial_unit_pkg::RX_BUSY
        && s.rx_sub == 4'h0)
        else $error("start edge not taken");
    a_sample_point: assert property (s.rx_st == serial_unit_pkg::RX_BUSY &&
        !(tick && s.rx_sub == `SAMPLE_SUB) |=> $stable(s.rx_bits))
        else $error("bit latched off the eighth pulse");
    a_frame_len: assert property (frame_len(s.ctrl) >= `FRAME_MIN &&
        frame_len(s.ctrl) <= `FRAME_MAX)
        else $error("frame length out of range");
    a_break_framing: assert property (rx_done && !rx_stop |=> s.flags.framing)
        else $error("break without framing flag");
    a_overrun_keep: assert property (rx_done && s.flags.rx_full &&
        !(I_WR && I_ADDR == `ADR_STATUS && I_WDATA[`ST_RX_FULL]) &&
        !(I_RD && I_ADDR == `ADR_RXDATA) |=> s.flags.overrun && $stable(s.rdr))
        else $error("overrun moved data");
    a_tx_req_own: assert property (O_TX_DONE_REQ == (s.flags.tx_done && s.ctrl.txd_ie)
        && O_TX_EMPTY_REQ == (s.flags.tx_empty && s.ctrl.txe_ie))
        else $error("tx request gate wrong");
    a_rx_req_drop: assert property ($fell(s.ctrl.rx_ie) |-> !O_RX_FULL_REQ && !O_RX_FAULT_REQ)
        else $error("rx request outlived enable");

endmodule

/* File: sim/serial_peer.sv */
`timescale 1ns/100ps

module serial_peer #(
    parameter int BIT_CYC = 16
) (
    input  wire logic i_clk,
    input  wire logic i_line,
    output logic      o_line
);
    // ****************
    // remote station
    // ****************
    initial o_line = 1'b1;

    // ten bit periods: start, eight data lsb first, stop
    task automatic send(input logic [7:0] d, input logic stp);
        logic [9:0] f;
        f = {stp, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge i_clk);
            o_line <= f[i];
            repeat (BIT_CYC - 1) @(posedge i_clk);
        end
        // one idle bit so the next start edge is a real falling edge
        @(posedge i_clk);
        o_line <= 1'b1;
        repeat (BIT_CYC - 1) @(posedge i_clk);
    endtask

    // samples mid bit; returns halfway through the last data bit
    task automatic catch(output logic [7:0] d);
        do @(posedge i_clk); while (i_line !== 1'b0);
        repeat (BIT_CYC / 2) @(posedge i_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge i_clk);
            d[i] = i_line;
        end
    endtask
endmodule

/* File: sim/serial_irq_break_sampling_test.sv */
`timescale 1ns/100ps
`include "serial_unit_defines.svh"

module serial_irq_break_sampling_test;
    // ****************
    // signals
    // ****************
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] port;
        logic [4:0] exp;
    } row_t;

    logic       clk;
    logic       srst;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       rxd;
    logic       o_txd;
    logic       o_oe_n;
    logic       o_irq;
    logic       o_rxf;
    logic       o_txe;
    logic       o_txdn;
    logic       o_rxe;
    logic       pin;
    logic [3:0] req;
    logic [7:0] v;
    logic [7:0] g;
    int         err_total;
    int         tests_run;
    int         cyc;
    // {rx full, tx empty, tx done, rx fault, oe_n}
    row_t       rows [5] = '{'{8'h01, 8'h00, 5'b01001}, '{8'h04, 8'h01, 5'b00100},
                             '{8'h05, 8'h03, 5'b01100}, '{8'h02, 8'h00, 5'b00001},
                             '{8'h00, 8'h02, 5'b00001}};

    // released pin floats high through an external pull-up
    assign pin = o_oe_n ? 1'b1 : o_txd;
    assign req = {o_rxf, o_txe, o_txdn, o_rxe};

    serial_unit #(.BASIC_DIV(8'h01)) DUT (
        .I_REF_CLK      (clk),
        .I_SRST         (srst),
        .I_ADDR         (addr),
        .I_WDATA        (wdata),
        .I_WR           (wr),
        .I_RD           (rd),
        .O_RDATA        (rdata),
        .I_RXD          (rxd),
        .O_TXD          (o_txd),
        .O_TXD_OE_N     (o_oe_n),
        .O_IRQ          (o_irq),
        .O_RX_FULL_REQ  (o_rxf),
        .O_TX_EMPTY_REQ (o_txe),
        .O_TX_DONE_REQ  (o_txdn),
        .O_RX_FAULT_REQ (o_rxe)
    );

    serial_peer #(.BIT_CYC(16)) peer (
        .i_clk  (clk),
        .i_line (pin),
        .o_line (rxd)
    );

    // ****************
    // tasks
    // ****************
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ****************
    // clock, watchdog
    // ****************
    always #20 clk = ~clk;

    // whole run is near 1500 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            err_total++;
            wrap_up();
        end
    end

    // ****************
    // sequence
    // ****************
    initial begin
        clk = 1'b0;
        srst = 1'b1;
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        err_total = 0;
        tests_run = 0;
        cyc = 0;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        settle();
        rd_reg(`ADR_STATUS, v); chk(v, 8'h03);
        chk({4'h0, req}, 8'h00);
        rd_reg(4'hf, v); chk(v, 8'h00);
        for (int i = 0; i < 5; i++) begin
            wr_reg(`ADR_CTRL, rows[i].ctrl);
            wr_reg(`ADR_PORT, rows[i].port);
            settle();
            chk({3'h0, req, o_oe_n}, {3'h0, rows[i].exp});
            if (rows[i].port[0])
                chk({7'h0, o_txd}, {7'h0, rows[i].port[1]});
        end
        wr_reg(`ADR_FORMAT, 8'h03);
        rd_reg(`ADR_FORMAT, v); chk(v, 8'h03);
        wr_reg(`ADR_FORMAT, 8'h00);
        // good frame, interrupt unmasked, raised, cleared
        wr_reg(`ADR_CTRL, 8'h12);
        wr_reg(`ADR_MASK, 8'h01);
        peer.send(8'ha5, 1'b1);
        settle();
        chk({6'h0, o_rxf, o_irq}, 8'h03);
        rd_reg(`ADR_RXDATA, v); chk(v, 8'ha5);
        wr_reg(`ADR_EVT, 8'h0f);
        settle();
        chk({6'h0, o_rxf, o_irq}, 8'h00);
        // overrun keeps the first byte
        peer.send(8'h3c, 1'b1);
        peer.send(8'hc3, 1'b1);
        settle();
        rd_reg(`ADR_STATUS, v); chk(v & 8'h0c, 8'h0c);
        chk({7'h0, o_rxe}, 8'h01);
        rd_reg(`ADR_RXDATA, v); chk(v, 8'h3c);
        wr_reg(`ADR_STATUS, 8'h38);
        // break: line low for the whole frame
        fork
            peer.send(8'h00, 1'b0);
            begin
                repeat (60) @(posedge clk);
                rd_reg(`ADR_LINE, v); chk(v & 8'h01, 8'h00);
            end
        join
        rd_reg(`ADR_STATUS, v); chk(v & 8'h10, 8'h10);
        chk({7'h0, o_rxe}, 8'h01);
        wr_reg(`ADR_STATUS, 8'h10);
        rd_reg(`ADR_STATUS, v); chk(v & 8'h10, 8'h00);
        peer.send(8'h00, 1'b0);
        rd_reg(`ADR_STATUS, v); chk(v & 8'h10, 8'h10);
        wr_reg(`ADR_CTRL, 8'h02);
        rd_reg(`ADR_STATUS, v); chk(v & 8'h10, 8'h10);
        // odd parity on zero data: parity bit low is wrong, idle high ends it cleanly
        wr_reg(`ADR_STATUS, 8'h3c);
        wr_reg(`ADR_CTRL, 8'hd0);
        peer.send(8'h00, 1'b0);
        rd_reg(`ADR_STATUS, v); chk(v & 8'h30, 8'h20);
        // synchronous mode holds the start while an error stands
        wr_reg(`ADR_CTRL, 8'h28);
        wr_reg(`ADR_TXHOLD, 8'h5a);
        repeat (40) @(posedge clk);
        rd_reg(`ADR_STATUS, v); chk(v & 8'h31, 8'h20);
        wr_reg(`ADR_EVT, 8'h0f);
        fork
            peer.catch(g);
            wr_reg(`ADR_STATUS, 8'h3e);
        join
        chk(g, 8'h5a);
        repeat (40) @(posedge clk);
        rd_reg(`ADR_STATUS, v); chk(v & 8'h03, 8'h03);
        rd_reg(`ADR_EVT, v); chk(v & 8'h06, 8'h06);
        wr_reg(`ADR_CTRL, 8'h2d);
        settle();
        chk({6'h0, o_txe, o_txdn}, 8'h03);
        // break sent by aborting a frame of ones
        wr_reg(`ADR_PORT, 8'h01);
        wr_reg(`ADR_CTRL, 8'h08);
        wr_reg(`ADR_TXHOLD, 8'hff);
        repeat (50) @(posedge clk);
        wr_reg(`ADR_CTRL, 8'h00);
        settle();
        chk({6'h0, o_oe_n, o_txd}, 8'h00);
        repeat (30) @(posedge clk);
        chk({6'h0, o_oe_n, o_txd}, 8'h00);
        wr_reg(`ADR_PORT, 8'h03);
        settle();
        chk({6'h0, o_oe_n, o_txd}, 8'h01);
        wrap_up();
    end
endmodule
